// ===== design/epv_defs.svh
// epv_defs.svh: offsets, pin codes and timing counts for the eprom program/verify pair
// assumes a 100 MHz clock on both ends and that this file is included by bare name
`ifndef EPV_DEFS_SVH
`define EPV_DEFS_SVH

`define EPV_CLK_NS         10
// device oscillator made by the programmer: 100 MHz / (2*10) = 5 MHz
`define EPV_OSC_HALF_CYC   10
`define EPV_TCLCL_NS       200
// 48 oscillator periods of setup/hold, rounded up to clock cycles
`define EPV_T48_CYC        ((48*`EPV_TCLCL_NS+`EPV_CLK_NS-1)/`EPV_CLK_NS)
`define EPV_VPP_SETUP_US   10
`define EPV_VPP_SETUP_CYC  ((`EPV_VPP_SETUP_US*1000+`EPV_CLK_NS-1)/`EPV_CLK_NS)
`define EPV_PULSE_GAP_US   10
`define EPV_PULSE_GAP_CYC  ((`EPV_PULSE_GAP_US*1000+`EPV_CLK_NS-1)/`EPV_CLK_NS)
`define EPV_PULSE_W_US     100
`define EPV_PULSE_W_CYC    ((`EPV_PULSE_W_US*1000)/`EPV_CLK_NS)
`define EPV_PULSES_CODE    5
`define EPV_PULSES_OTHER   25

// mode select pattern {a, enable, c, d, e}
`define EPV_SEL_PROG_CODE  5'h0F
`define EPV_SEL_VERIFY     5'h03
`define EPV_SEL_PROG_ENC   5'h0D
`define EPV_SEL_LOCK1      5'h1F
`define EPV_SEL_LOCK2      5'h1C
`define EPV_SEL_LOCK3      5'h16
`define EPV_SEL_SIGNATURE  5'h00

`define EPV_SIG_ADDR0      15'h0030
`define EPV_SIG_ADDR1      15'h0031
`define EPV_SIG_ADDR2      15'h0060
`define EPV_ERASED_BYTE    8'hFF

// programmer register map (byte offsets)
`define EPV_REG_CMD        8'h00
`define EPV_REG_ADDR       8'h04
`define EPV_REG_DATA       8'h08
`define EPV_REG_STATUS     8'h0C
`define EPV_REG_RDATA      8'h10
`define EPV_REG_SESSION    8'h14
`define EPV_ST_BUSY        0
`define EPV_ST_DONE        1
`define EPV_ST_ERR         2

`endif

// ===== design/epv_device.sv
// epv_device: code eprom with encryption array, lock bits and signature bytes behind the programming pins
// assumes pins come from logic on the same clock, so they are used unsynchronised
`timescale 1ns/1ps
`default_nettype none
`include "epv_defs.svh"

// Contract
// - programmer runs device oscillator at 4-6 MHz
// - address from three ports, data on byte lines
// - code/encryption program pin levels at 12.75V
// - address, data, mode stable before supply raise
// - five pulses per code byte, 25 otherwise
// - repeat steps for every location
// - supply raised only around the strobe pulses
// - verify and signature-read pin levels
// - lock bit pin combinations at 12.75V
// - verify output is code XNOR encryption byte
// - lock bits never readable on pins
// - erase restores all ones, clears locks
// - mask variant: encryption needs its lock bit
// - fill unused code with varied non-FF values
// - verify per byte or block, full advised
// - lock one: table loads, EA latch, no programming
// - locks one and two: verify also blocked
// - all locks: external execution blocked
// - three signature bytes at 30H, 31H, 60H
module epv_device #(
  parameter int         CODE_AW      = 12,
  parameter bit         MASK_VARIANT = 1'b0,
  parameter logic [7:0] SIG_BYTE0    = 8'hA5,  // arbitrary value
  parameter logic [7:0] SIG_BYTE1    = 8'h3C,  // arbitrary value
  parameter logic [7:0] SIG_BYTE2    = 8'h96   // arbitrary value
) (
  input  wire logic   clock,                   // 100 MHz clock
  input  wire logic   resetn,                  // async reset, active low
  epv_pins_if.device  pins,                    // programming pins
  input  wire logic   erase_req,               // one-cycle pulse: erase whole array
  output logic        code_table_load_blocked, // table loads from external code may not read inside
  output logic        verify_blocked,          // verify reads are refused
  output logic        ext_exec_blocked,        // external execution refused
  output logic        ext_access_level,        // effective external-access level
  output logic        prog_refused,            // one-cycle pulse: a program pulse was refused
  output logic [4:0]  pulse_count              // strobe pulses seen on the current location
);
  import epv_pkg::*;

  localparam int CODE_DEPTH = 1 << CODE_AW;

  typedef enum logic [2:0] {
    EPV_M_NONE,
    EPV_M_PROG_CODE,
    EPV_M_PROG_ENC,
    EPV_M_VERIFY,
    EPV_M_LOCK1,
    EPV_M_LOCK2,
    EPV_M_LOCK3,
    EPV_M_SIGNATURE
  } epv_mode_type;

  typedef struct packed {
    logic [CODE_DEPTH-1:0][7:0] code;
    logic [63:0][7:0]           enc;
    logic [2:0]                 lock;
    logic                       enc_written;
    logic                       strobe_q;
    logic                       rst_q;
    logic                       ea_eff;
    logic [14:0]                addr_q;
    logic [4:0]                 pulses;
    logic                       refused;
    logic [7:0]                 dout;
    logic                       doe;
  } epv_dev_state_type;

  epv_dev_state_type s_r;
  epv_dev_state_type s_nxt;
  epv_mode_type      mode;
  logic [14:0]       addr;
  logic [4:0]        sel;
  logic              pulse_end;
  logic              in_range;
  logic [7:0]        code_byte;
  logic [7:0]        enc_byte;
  logic [7:0]        sig_byte;

  assign addr = {pins.top_address_pin, pins.high_address_port, pins.low_address_port};
  assign sel  = {pins.mode_select_a, pins.mode_select_enable, pins.mode_select_c,
                 pins.mode_select_d, pins.mode_select_e};
  assign in_range = (addr >> CODE_AW) == 15'h0000;

  always_comb begin
    mode = EPV_M_NONE;
    // a session needs reset held high and the fetch strobe low
    if (pins.reset_pin && !pins.program_fetch_strobe_n) begin
      case (sel)
        `EPV_SEL_PROG_CODE: mode = EPV_M_PROG_CODE;
        `EPV_SEL_PROG_ENC:  mode = EPV_M_PROG_ENC;
        `EPV_SEL_VERIFY:    mode = EPV_M_VERIFY;
        `EPV_SEL_LOCK1:     mode = EPV_M_LOCK1;
        `EPV_SEL_LOCK2:     mode = EPV_M_LOCK2;
        `EPV_SEL_LOCK3:     mode = EPV_M_LOCK3;
        `EPV_SEL_SIGNATURE: mode = EPV_M_SIGNATURE;
        default:            mode = EPV_M_NONE;
      endcase
    end
  end

  always_comb begin
    code_byte = in_range ? s_r.code[addr[CODE_AW-1:0]] : `EPV_ERASED_BYTE;
    // on the mask part the table only takes part once its lock bit is set
    if (MASK_VARIANT && !s_r.lock[0]) begin
      enc_byte = `EPV_ERASED_BYTE;
    end else begin
      enc_byte = s_r.enc[addr[5:0]];
    end
    case (addr)
      `EPV_SIG_ADDR0: sig_byte = SIG_BYTE0;
      `EPV_SIG_ADDR1: sig_byte = SIG_BYTE1;
      `EPV_SIG_ADDR2: sig_byte = SIG_BYTE2;
      default:        sig_byte = `EPV_ERASED_BYTE;
    endcase
  end

  // a pulse counts at its rising end, and only with the supply raised
  assign pulse_end = pins.latch_and_program_strobe_n && !s_r.strobe_q && pins.supply_raised;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.strobe_q = pins.latch_and_program_strobe_n;
    s_nxt.rst_q    = pins.reset_pin;
    s_nxt.addr_q   = addr;
    s_nxt.refused  = 1'b0;
    if (addr != s_r.addr_q) begin
      s_nxt.pulses = 5'h00;
    end
    if (pulse_end && mode != EPV_M_NONE && mode != EPV_M_VERIFY && mode != EPV_M_SIGNATURE) begin
      if (s_r.pulses != 5'h1F) begin
        s_nxt.pulses = s_r.pulses + 5'h01;
      end
    end
    if (pulse_end) begin
      case (mode)
        EPV_M_PROG_CODE: begin
          // eprom cells only go from one to zero, so each pulse ands in the data
          if (s_r.lock[0] || !in_range) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.code[addr[CODE_AW-1:0]] = code_byte & pins.byte_port_lines;
          end
        end
        EPV_M_PROG_ENC: begin
          if (s_r.lock[0]) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.enc[addr[5:0]] = s_r.enc[addr[5:0]] & pins.byte_port_lines;
            s_nxt.enc_written    = 1'b1;
          end
        end
        EPV_M_LOCK1: begin
          if (MASK_VARIANT && !s_r.enc_written) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.lock[0] = 1'b1;
          end
        end
        EPV_M_LOCK2: begin
          if (MASK_VARIANT) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.lock[1] = 1'b1;
          end
        end
        EPV_M_LOCK3: begin
          if (MASK_VARIANT) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.lock[2] = 1'b1;
          end
        end
        default: begin
          s_nxt.refused = 1'b0;
        end
      endcase
    end
    // the lines are released unless a read is being answered
    s_nxt.doe = 1'b0;
    if (mode == EPV_M_VERIFY && pins.latch_and_program_strobe_n && !pins.supply_raised
        && !(s_r.lock[0] && s_r.lock[1])) begin
      s_nxt.doe  = 1'b1;
      s_nxt.dout = ~(code_byte ^ enc_byte);
    end else if (mode == EPV_M_SIGNATURE && pins.latch_and_program_strobe_n && !pins.supply_raised) begin
      s_nxt.doe  = 1'b1;
      s_nxt.dout = sig_byte;
    end
    // lock bits are never driven onto the byte lines; they gate programming, verify reads and the protection outputs
    if (!s_r.lock[0]) begin
      s_nxt.ea_eff = pins.external_access_program_supply;
    end else if (s_r.rst_q && !pins.reset_pin) begin
      s_nxt.ea_eff = pins.external_access_program_supply;
    end
    if (erase_req) begin
      s_nxt.code        = {CODE_DEPTH{`EPV_ERASED_BYTE}};
      s_nxt.enc         = {64{`EPV_ERASED_BYTE}};
      s_nxt.lock        = 3'h0;
      s_nxt.enc_written = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r             <= '0;
      s_r.code        <= {CODE_DEPTH{`EPV_ERASED_BYTE}};
      s_r.enc         <= {64{`EPV_ERASED_BYTE}};
      s_r.strobe_q    <= 1'b1;
      s_r.dout        <= `EPV_ERASED_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.dev_byte_out       = s_r.dout;
  assign pins.dev_byte_oe        = s_r.doe;
  assign code_table_load_blocked = s_r.lock[0];
  assign verify_blocked          = s_r.lock[0] & s_r.lock[1];
  assign ext_exec_blocked        = &s_r.lock;
  assign ext_access_level        = s_r.ea_eff;
  assign prog_refused            = s_r.refused;
  assign pulse_count             = s_r.pulses;
endmodule
`default_nettype wire

// ===== design/epv_pins_if.sv
// epv_pins_if: the pins between the programmer and the device
// assumes both ends share one clock; the byte lines resolve here with a pull-up
`timescale 1ns/1ps
`default_nettype none
interface epv_pins_if;
  logic       device_osc;
  logic       reset_pin;
  logic       program_fetch_strobe_n;
  logic       latch_and_program_strobe_n;
  logic       external_access_program_supply;
  logic       supply_raised;
  logic       mode_select_a;
  logic       mode_select_enable;
  logic       mode_select_c;
  logic       mode_select_d;
  logic       mode_select_e;
  logic [7:0] low_address_port;
  logic [5:0] high_address_port;
  logic       top_address_pin;
  logic [7:0] host_byte_out;
  logic       host_byte_oe;
  logic [7:0] dev_byte_out;
  logic       dev_byte_oe;
  logic [7:0] byte_port_lines;

  // undriven lines float high through the pull-up
  assign byte_port_lines = dev_byte_oe ? dev_byte_out : (host_byte_oe ? host_byte_out : 8'hFF);

  modport device (
    input  device_osc, reset_pin, program_fetch_strobe_n, latch_and_program_strobe_n,
    input  external_access_program_supply, supply_raised,
    input  mode_select_a, mode_select_enable, mode_select_c, mode_select_d, mode_select_e,
    input  low_address_port, high_address_port, top_address_pin, byte_port_lines,
    output dev_byte_out, dev_byte_oe
  );
  modport host (
    output device_osc, reset_pin, program_fetch_strobe_n, latch_and_program_strobe_n,
    output external_access_program_supply, supply_raised,
    output mode_select_a, mode_select_enable, mode_select_c, mode_select_d, mode_select_e,
    output low_address_port, high_address_port, top_address_pin,
    output host_byte_out, host_byte_oe,
    input  byte_port_lines
  );
endinterface
`default_nettype wire

// ===== design/epv_pkg.sv
// epv_pkg: shared types of the eprom program/verify pair
// assumes nothing beyond a SystemVerilog compiler
package epv_pkg;
  typedef enum logic [2:0] {
    EPV_OP_PROG_CODE,
    EPV_OP_VERIFY,
    EPV_OP_PROG_ENC,
    EPV_OP_LOCK1,
    EPV_OP_LOCK2,
    EPV_OP_LOCK3,
    EPV_OP_SIGNATURE,
    EPV_OP_NONE
  } epv_op_type;

  typedef enum logic [2:0] {
    EPV_H_IDLE,
    EPV_H_SETUP,
    EPV_H_RAISE,
    EPV_H_PULSE_LO,
    EPV_H_PULSE_HI,
    EPV_H_HOLD
  } epv_host_state_type;
endpackage

// ===== design/epv_programmer.sv
// epv_programmer: apb-controlled programmer that drives the device's programming pins
// assumes a zero-wait apb master on the same 100 MHz clock as the device
`timescale 1ns/1ps
`default_nettype none
`include "epv_defs.svh"

module epv_programmer #(
  parameter int PULSE_W_CYC   = `EPV_PULSE_W_CYC,
  parameter int PULSE_GAP_CYC = `EPV_PULSE_GAP_CYC
) (
  input  wire logic        clock,    // 100 MHz clock
  input  wire logic        resetn,   // async reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready, always high
  output logic             pslverr,  // apb error on unmapped address
  epv_pins_if.host         pins      // programming pins
);
  import epv_pkg::*;

  typedef struct packed {
    epv_host_state_type st;
    epv_op_type         op;
    logic [15:0]        cnt;
    logic [4:0]         pulses;
    logic [14:0]        addr;
    logic [7:0]         wdata;
    logic [7:0]         rdata;
    logic               session;
    logic               done;
    logic               err;
    logic [4:0]         osc_cnt;
    logic               osc;
    logic [4:0]         sel;
    logic               doe;
    logic               raised;
    logic               strobe_n;
  } epv_host_reg_type;

  epv_host_reg_type s_r;
  epv_host_reg_type s_nxt;
  logic             access;
  logic             mapped;
  logic [4:0]       need;

  function automatic logic [4:0] op_sel(input epv_op_type op);
    case (op)
      EPV_OP_PROG_CODE: op_sel = `EPV_SEL_PROG_CODE;
      EPV_OP_PROG_ENC:  op_sel = `EPV_SEL_PROG_ENC;
      EPV_OP_VERIFY:    op_sel = `EPV_SEL_VERIFY;
      EPV_OP_LOCK1:     op_sel = `EPV_SEL_LOCK1;
      EPV_OP_LOCK2:     op_sel = `EPV_SEL_LOCK2;
      EPV_OP_LOCK3:     op_sel = `EPV_SEL_LOCK3;
      EPV_OP_SIGNATURE: op_sel = `EPV_SEL_SIGNATURE;
      default:          op_sel = `EPV_SEL_SIGNATURE;
    endcase
  endfunction

  assign access = psel & penable;
  assign mapped = paddr == `EPV_REG_CMD || paddr == `EPV_REG_ADDR || paddr == `EPV_REG_DATA ||
                  paddr == `EPV_REG_STATUS || paddr == `EPV_REG_RDATA || paddr == `EPV_REG_SESSION;
  assign need   = (s_r.op == EPV_OP_PROG_CODE) ? 5'(`EPV_PULSES_CODE) : 5'(`EPV_PULSES_OTHER);

  always_comb begin
    s_nxt = s_r;
    // free-running 5 MHz device oscillator
    s_nxt.osc_cnt = s_r.osc_cnt + 5'h01;
    if (s_r.osc_cnt == 5'(`EPV_OSC_HALF_CYC - 1)) begin
      s_nxt.osc_cnt = 5'h00;
      s_nxt.osc     = ~s_r.osc;
    end
    if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
    case (s_r.st)
      EPV_H_IDLE: begin
        s_nxt.st = EPV_H_IDLE;
      end
      EPV_H_SETUP: begin
        if (s_r.cnt == 16'h0000) begin
          if (s_r.op == EPV_OP_VERIFY || s_r.op == EPV_OP_SIGNATURE) begin
            s_nxt.rdata = pins.byte_port_lines;
            s_nxt.st    = EPV_H_IDLE;
            s_nxt.done  = 1'b1;
          end else begin
            s_nxt.raised = 1'b1;
            s_nxt.cnt    = 16'(`EPV_VPP_SETUP_CYC - 1);
            s_nxt.st     = EPV_H_RAISE;
          end
        end
      end
      EPV_H_RAISE: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.strobe_n = 1'b0;
          s_nxt.cnt      = 16'(PULSE_W_CYC - 1);
          s_nxt.st       = EPV_H_PULSE_LO;
        end
      end
      EPV_H_PULSE_LO: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.strobe_n = 1'b1;
          s_nxt.pulses   = s_r.pulses + 5'h01;
          s_nxt.cnt      = 16'(PULSE_GAP_CYC - 1);
          s_nxt.st       = EPV_H_PULSE_HI;
        end
      end
      EPV_H_PULSE_HI: begin
        if (s_r.cnt == 16'h0000) begin
          if (s_r.pulses == need) begin
            s_nxt.raised = 1'b0;
            s_nxt.cnt    = 16'(`EPV_T48_CYC - 1);
            s_nxt.st     = EPV_H_HOLD;
          end else begin
            s_nxt.strobe_n = 1'b0;
            s_nxt.cnt      = 16'(PULSE_W_CYC - 1);
            s_nxt.st       = EPV_H_PULSE_LO;
          end
        end
      end
      EPV_H_HOLD: begin
        // address and data stay put through the hold time, then the lines are released
        if (s_r.cnt == 16'h0000) begin
          s_nxt.doe  = 1'b0;
          s_nxt.st   = EPV_H_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = EPV_H_IDLE;
      end
    endcase
    if (access && pwrite) begin
      case (paddr)
        // pins must not move under a running operation
        `EPV_REG_ADDR: begin
          if (s_r.st == EPV_H_IDLE) begin
            s_nxt.addr = pwdata[14:0];
          end
        end
        `EPV_REG_DATA: begin
          if (s_r.st == EPV_H_IDLE) begin
            s_nxt.wdata = pwdata[7:0];
          end
        end
        `EPV_REG_SESSION: begin
          if (s_r.st == EPV_H_IDLE) begin
            s_nxt.session = pwdata[0];
          end
        end
        `EPV_REG_STATUS: begin
          if (pwdata[`EPV_ST_ERR]) begin
            s_nxt.err = 1'b0;
          end
        end
        `EPV_REG_CMD: begin
          // each command sets up one location; software repeats it per byte
          if (s_r.st == EPV_H_IDLE && s_r.session && pwdata[2:0] != 3'h7) begin
            s_nxt.op     = epv_op_type'(pwdata[2:0]);
            s_nxt.sel    = op_sel(epv_op_type'(pwdata[2:0]));
            s_nxt.doe    = pwdata[2:0] != 3'h1 && pwdata[2:0] != 3'h6;
            s_nxt.pulses = 5'h00;
            s_nxt.done   = 1'b0;
            s_nxt.cnt    = 16'(`EPV_T48_CYC - 1);
            s_nxt.st     = EPV_H_SETUP;
          end else begin
            s_nxt.err = 1'b1;
          end
        end
        default: begin
          s_nxt.err = s_nxt.err;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r          <= '0;
      s_r.st       <= EPV_H_IDLE;
      s_r.op       <= EPV_OP_NONE;
      s_r.strobe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        `EPV_REG_CMD:     prdata = {29'h0, s_r.op};
        `EPV_REG_ADDR:    prdata = {17'h0, s_r.addr};
        `EPV_REG_DATA:    prdata = {24'h0, s_r.wdata};
        `EPV_REG_STATUS:  prdata = {29'h0, s_r.err, s_r.done, s_r.st != EPV_H_IDLE};
        `EPV_REG_RDATA:   prdata = {24'h0, s_r.rdata};
        `EPV_REG_SESSION: prdata = {31'h0, s_r.session};
        default:          prdata = 32'h0000_0000;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  assign pins.device_osc                     = s_r.osc;
  assign pins.reset_pin                      = s_r.session;
  assign pins.program_fetch_strobe_n         = ~s_r.session;
  assign pins.latch_and_program_strobe_n     = s_r.strobe_n;
  assign pins.external_access_program_supply = 1'b1;
  assign pins.supply_raised                  = s_r.raised;
  assign {pins.mode_select_a, pins.mode_select_enable, pins.mode_select_c,
          pins.mode_select_d, pins.mode_select_e} = s_r.sel;
  assign pins.low_address_port               = s_r.addr[7:0];
  assign pins.high_address_port              = s_r.addr[13:8];
  assign pins.top_address_pin                = s_r.addr[14];
  assign pins.host_byte_out                  = s_r.wdata;
  assign pins.host_byte_oe                   = s_r.doe;
endmodule
`default_nettype wire

// ===== testbench/epv_link_assertions.sv
// epv_link_assertions: pin-level checks between the programmer and the device
// assumes one clock for both ends; wired to the pin interface by the bench
`timescale 1ns/1ps
`default_nettype none
`include "epv_defs.svh"
module epv_link_assertions #(
  parameter int PW = 20
) (
  input wire logic       clock,                      // clock
  input wire logic       resetn,                     // reset, active low
  input wire logic       reset_pin,                  // session pin
  input wire logic       program_fetch_strobe_n,     // fetch strobe
  input wire logic       latch_and_program_strobe_n, // program strobe
  input wire logic       supply_raised,              // supply at programming level
  input wire logic       mode_select_a,              // mode
  input wire logic       mode_select_enable,         // mode
  input wire logic       mode_select_c,              // mode
  input wire logic       mode_select_d,              // mode
  input wire logic       mode_select_e,              // mode
  input wire logic [7:0] low_address_port,           // address
  input wire logic [5:0] high_address_port,          // address
  input wire logic       dev_byte_oe                 // device drives bytes
);
  localparam int LO = PW - 1;
  localparam int HI = PW + 1;
  logic [4:0] sel;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  assign sel = {mode_select_a, mode_select_enable, mode_select_c, mode_select_d, mode_select_e};
  AST_SESSION_PINS: assert property (supply_raised |-> reset_pin && !program_fetch_strobe_n)
    else $error("supply raised outside a session");
  AST_STROBE_IN_SUPPLY: assert property (!latch_and_program_strobe_n |-> supply_raised)
    else $error("strobe pulsed without raised supply");
  AST_ADDR_HELD: assert property (supply_raised |-> $stable(low_address_port) && $stable(sel))
    else $error("address or mode moved under raised supply");
  AST_RAISE_MODE: assert property ($rose(supply_raised) |-> sel inside {`EPV_SEL_PROG_CODE,
    `EPV_SEL_PROG_ENC, `EPV_SEL_LOCK1, `EPV_SEL_LOCK2, `EPV_SEL_LOCK3}) else $error("supply raised in no program mode");
  AST_PULSE_LEN: assert property ($fell(latch_and_program_strobe_n) |-> ##[LO:HI] $rose(latch_and_program_strobe_n))
    else $error("strobe pulse of wrong width");
  AST_FLOAT: assert property (!(sel inside {`EPV_SEL_VERIFY, `EPV_SEL_SIGNATURE}) |=> !dev_byte_oe)
    else $error("device drives bytes outside a read mode");
  AST_NO_DRIVE_SUPPLY: assert property (supply_raised |=> !dev_byte_oe)
    else $error("device drives bytes under raised supply");
  AST_SIG_DRIVE: assert property ((reset_pin && sel == `EPV_SEL_SIGNATURE && !supply_raised && high_address_port == 6'h00
    && low_address_port == 8'h30 && latch_and_program_strobe_n) [*2] |-> dev_byte_oe) else $error("signature not driven");
  cover property ($rose(dev_byte_oe));
  cover property ($fell(latch_and_program_strobe_n));
  cover property ($rose(supply_raised));
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// testbench: apb-driven programmer against the device, checked against a byte model
// assumes the design files and the checker compile first
`timescale 1ns/1ps
`default_nettype none
`include "epv_defs.svh"
module testbench;
  localparam int PW = 20;
  logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, erase_req = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, tl_blk, v_blk, x_blk, ea_lvl, refused;
  logic [4:0]  pcnt;
  int          error_cnt = 0, tests_run = 0, seed = 32'hc925, l1 = 0, l2 = 0, hit = 0, a, d;
  int          code [int];
  int          enc [64];
  always #5 clock = ~clock;
  always @(posedge clock) if (refused === 1'b1) hit <= 1;
  epv_pins_if pins_bus ();
  epv_device #(.SIG_BYTE0(8'h5A), .SIG_BYTE1(8'hC3), .SIG_BYTE2(8'h69)) u_epv_device (.clock(clock),
    .resetn(resetn), .pins(pins_bus), .erase_req(erase_req), .code_table_load_blocked(tl_blk),
    .verify_blocked(v_blk), .ext_exec_blocked(x_blk), .ext_access_level(ea_lvl), .prog_refused(refused),
    .pulse_count(pcnt));
  epv_programmer #(.PULSE_W_CYC(PW), .PULSE_GAP_CYC(PW)) u_epv_programmer (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins_bus));
  epv_link_assertions #(.PW(PW)) u_chk (.clock(clock), .resetn(resetn), .reset_pin(pins_bus.reset_pin),
    .program_fetch_strobe_n(pins_bus.program_fetch_strobe_n), .supply_raised(pins_bus.supply_raised),
    .latch_and_program_strobe_n(pins_bus.latch_and_program_strobe_n), .mode_select_a(pins_bus.mode_select_a),
    .mode_select_enable(pins_bus.mode_select_enable), .mode_select_c(pins_bus.mode_select_c),
    .mode_select_d(pins_bus.mode_select_d), .mode_select_e(pins_bus.mode_select_e),
    .low_address_port(pins_bus.low_address_port), .high_address_port(pins_bus.high_address_port),
    .dev_byte_oe(pins_bus.dev_byte_oe));
  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one transfer, then an idle cycle so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic run(input int op, input int ad, input int dt);
    int n;
    apb(1, `EPV_REG_ADDR, ad);
    apb(1, `EPV_REG_DATA, dt);
    apb(1, `EPV_REG_CMD, op);
    n = 0;
    do begin
      apb(0, `EPV_REG_STATUS, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      error_cnt++;
      end_sim();
    end
    if (op == 0 && l1 == 0) code[ad] = (code.exists(ad) ? code[ad] : 'hFF) & dt;
    if (op == 2 && l1 == 0) enc[ad & 63] &= dt;
    if (op == 3) l1 = 1;
    if (op == 4) l2 = 1;
  endtask
  task automatic ver(input int ad);
    int c;
    c = code.exists(ad) ? code[ad] : 'hFF;
    run(1, ad, 0);
    apb(0, `EPV_REG_RDATA, 0);
    chk("verify byte", (l1 && l2) ? 32'hFF : 32'(~(c ^ enc[ad & 63]) & 'hFF), rd);
  endtask
  initial begin
    foreach (enc[i]) enc[i] = 'hFF;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    apb(1, `EPV_REG_SESSION, 1);
    a = $random(seed) & 'hFFF;
    d = $random(seed) & 'hFE;
    run(0, a, d);
    chk("code pulses", 5, pcnt);
    ver(a);
    run(2, a ^ 64, $random(seed) & 'hFF);
    chk("enc pulses", 25, pcnt);
    ver(a);
    for (int i = 0; i < 4; i++) begin
      run(6, i == 0 ? 'h30 : i == 1 ? 'h31 : i == 2 ? 'h60 : 'h61, 0);
      apb(0, `EPV_REG_RDATA, 0);
      chk("signature", i == 0 ? 'h5A : i == 1 ? 'hC3 : i == 2 ? 'h69 : 'hFF, rd);
    end
    apb(0, 8'h18, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    run(3, a, 0);
    chk("table load lock", 1, tl_blk);
    chk("ea level", 1, ea_lvl);
    run(0, a ^ 1, 0);
    chk("program refused", 1, hit);
    ver(a ^ 1);
    run(4, a, 0);
    chk("verify lock", 1, v_blk);
    ver(a);
    run(5, a, 0);
    chk("exec lock", 1, x_blk);
    erase_req <= 1'b1;
    @(posedge clock);
    erase_req <= 1'b0;
    repeat (2) @(posedge clock);
    chk("erase unlocks", 0, {tl_blk, v_blk, x_blk});
    l1 = 0;
    l2 = 0;
    code.delete();
    foreach (enc[i]) enc[i] = 'hFF;
    ver(a);
    end_sim();
  end
endmodule
`default_nettype wire
